/* File: hw/l2edc_pkg.sv */
// Constants and types for the level-2 EDC status and command register block.
// Assumes one 32-bit memory-mapped register port on the memory subsystem clock.
package l2edc_pkg;
  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [31:0] L2EDC_STATUS_ADDR = 32'h0184_6004; // Status, read only
  localparam logic [31:0] L2EDC_CMD_ADDR    = 32'h0184_6008; // Command, write only
  localparam logic [31:0] L2EDC_LOC_ADDR    = 32'h0184_600C; // Fault location, read only
  localparam logic [31:0] L2EDC_ZERO_WORD   = 32'h0000_0000; // Reserved and unmapped answer

  // ------------------------------------------------------------------
  // Field positions (status and command share bits 6..0)
  // ------------------------------------------------------------------
  localparam int STAT_INDEX_LSB = 16;
  localparam int STAT_CLASS_LSB = 8;
  localparam int BIT_DMA        = 6;
  localparam int BIT_PROG       = 5;
  localparam int BIT_DATA       = 4;
  localparam int BIT_PAUSE      = 3;
  localparam int BIT_OFF        = 2;
  localparam int BIT_ON         = 0;
  localparam int LOC_ADDR_LSB   = 5;
  localparam int LOC_WAY_LSB    = 3;
  localparam int LOC_RAM_BIT    = 0;
  localparam int LOC_ADDR_W     = 27;
  localparam int WAY_W          = 2;
  localparam int INDEX_W        = 8;
  localparam int CLASS_W        = 2;

  // ------------------------------------------------------------------
  // Fault flag vector layout {dma, prog, data}
  // ------------------------------------------------------------------
  localparam int FLAG_DMA  = 2;
  localparam int FLAG_PROG = 1;
  localparam int FLAG_DATA = 0;

  // ------------------------------------------------------------------
  // Fault class codes and zero values
  // ------------------------------------------------------------------
  localparam logic [1:0]  CLASS_SINGLE  = 2'h0; // Correctable data bit
  localparam logic [1:0]  CLASS_DOUBLE  = 2'h1; // Not correctable
  localparam logic [1:0]  CLASS_RSVD    = 2'h2; // Never recorded
  localparam logic [1:0]  CLASS_PARITY  = 2'h3; // Parity bits only, data good
  localparam logic [7:0]  INDEX_ZERO    = 8'h00;
  localparam logic [1:0]  WAY_ZERO      = 2'h0;
  localparam logic [1:0]  LOC_RSV_ZERO  = 2'h0;
  localparam logic [2:0]  FLAGS_ZERO    = 3'h0;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {MODE_OFF, MODE_ON, MODE_PAUSED} l2edc_mode_t;
  typedef enum logic [1:0] {SRC_DMA, SRC_PROG, SRC_DATA} l2edc_src_t;
  localparam l2edc_mode_t L2EDC_RESET_MODE = MODE_OFF;
endpackage : l2edc_pkg

/* File: hw/l2edc_mode_ctrl.sv */
// Checking mode state: enabled, disabled or suspended.
// Assumes command bits arrive with a one-cycle write strobe on mclk_in.
`timescale 1ns/1ps
`default_nettype none
module l2edc_mode_ctrl (
  input  wire logic mclk_in,   // Memory subsystem clock
  input  wire logic srst_in,   // Synchronous reset, high
  input  wire logic cmd_wr_in, // Command register written
  input  wire logic pause_in,  // Suspend bit of the write
  input  wire logic off_in,    // Disable bit of the write
  input  wire logic on_in,     // Enable bit of the write
  output logic      paused_out,
  output logic      off_out,
  output logic      on_out
);
  import l2edc_pkg::*;

  l2edc_mode_t state_reg;  // Current mode
  l2edc_mode_t state_next; // Mode after this cycle

  // ------------------------------------------------------------------
  // Next mode; only bits written as 1 act
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (cmd_wr_in) begin
      case ({pause_in, off_in, on_in})
        3'h0:    state_next = state_reg;   // All zero: no effect
        3'h4:    state_next = MODE_PAUSED;
        3'h2:    state_next = MODE_OFF;
        3'h1:    state_next = MODE_ON;
        default: state_next = MODE_OFF;    // Conflicting bits act as disable
      endcase
    end
  end

  // One-hot flags are flops so the status bits never glitch
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_reg  <= L2EDC_RESET_MODE;
      paused_out <= 1'b0;
      off_out    <= 1'b1;
      on_out     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      paused_out <= (state_next == MODE_PAUSED);
      off_out    <= (state_next == MODE_OFF);
      on_out     <= (state_next == MODE_ON);
    end
  end

  multi_cmd_off_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (cmd_wr_in && (32'(pause_in) + 32'(off_in) + 32'(on_in) > 1)) |=> (off_out && !on_out))
    else $error("conflicting mode write did not disable");
  one_hot_mode_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    $onehot({paused_out, off_out, on_out}))
    else $error("mode flags not one-hot");
endmodule : l2edc_mode_ctrl
`default_nettype wire

/* File: hw/l2edc_fault_rec.sv */
// Fault record: flags, class, flipped bit index and location word.
// Assumes the access pipeline reports at most one fault per cycle.
`timescale 1ns/1ps
`default_nettype none
module l2edc_fault_rec (
  input  wire logic                  mclk_in,
  input  wire logic                  srst_in,
  input  wire logic                  accept_in,  // Checking enabled
  input  wire logic                  fault_in,   // One-cycle fault report
  input  wire l2edc_pkg::l2edc_src_t src_in,     // Access kind
  input  wire logic [1:0]            class_in,   // Fault class code
  input  wire logic [7:0]            index_in,   // Flipped bit position
  input  wire logic [26:0]           addr_in,    // Aligned address bits 31..5
  input  wire logic [1:0]            way_in,     // Cache way
  input  wire logic                  ram_in,     // Fault lies in RAM
  input  wire logic [2:0]            clear_in,   // Clear pulses {dma,prog,data}
  output logic      [2:0]            flags_out,
  output logic      [1:0]            class_out,
  output logic      [7:0]            index_out,
  output logic      [31:0]           loc_out
);
  import l2edc_pkg::*;

  logic [2:0] flags_kept; // Flags surviving this cycle's clears
  logic [2:0] src_bit;    // One-hot flag of the reported access
  logic       override;   // Uncorrectable replaces a correctable record
  logic       capture;    // Record is taken this cycle
  logic [1:0] class_eff;  // Class with reserved code mapped away

  // ------------------------------------------------------------------
  // Capture decision; a fault in a clear cycle wins over the clear
  // ------------------------------------------------------------------
  always_comb begin
    flags_kept = flags_out & ~clear_in;
    src_bit    = FLAGS_ZERO;
    case (src_in)
      SRC_DMA:  src_bit[FLAG_DMA]  = 1'b1;
      SRC_PROG: src_bit[FLAG_PROG] = 1'b1;
      SRC_DATA: src_bit[FLAG_DATA] = 1'b1;
      default:  src_bit = FLAGS_ZERO;
    endcase
    class_eff = (class_in == CLASS_RSVD) ? CLASS_DOUBLE : class_in;
    override  = (|flags_kept) && (class_eff == CLASS_DOUBLE) && (class_out != CLASS_DOUBLE);
    capture   = accept_in && fault_in && (!(|flags_kept) || override);
  end

  // Flags: only one record stands at a time
  always_ff @(posedge mclk_in) begin
    if (srst_in) flags_out <= FLAGS_ZERO;
    else if (capture) flags_out <= src_bit;
    else flags_out <= flags_kept;
  end

  // Class and bit index; index means something only for one flipped data bit
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      class_out <= CLASS_SINGLE;
      index_out <= INDEX_ZERO;
    end else if (capture) begin
      class_out <= class_eff;
      index_out <= (class_eff == CLASS_SINGLE) ? index_in : INDEX_ZERO;
    end
  end

  // Location word; any clear zeroes it unless a new fault lands
  always_ff @(posedge mclk_in) begin
    if (srst_in) loc_out <= L2EDC_ZERO_WORD;
    else if (capture) loc_out <= {addr_in, (ram_in ? WAY_ZERO : way_in),
                                  LOC_RSV_ZERO, ram_in};
    else if (|clear_in) loc_out <= L2EDC_ZERO_WORD;
  end

  ram_way_zero_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    loc_out[LOC_RAM_BIT] |-> (loc_out[LOC_WAY_LSB +: WAY_W] == WAY_ZERO))
    else $error("way field nonzero for RAM fault");
  hold_record_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    ((|flags_out) && clear_in == FLAGS_ZERO && class_out == CLASS_DOUBLE) |=> $stable(loc_out))
    else $error("recorded fault overwritten before clear");
  clear_zero_loc_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    ((|clear_in) && !fault_in) |=> (loc_out == L2EDC_ZERO_WORD && !(|(flags_out & $past(clear_in)))))
    else $error("clear left location or flag set");
  index_single_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    capture |=> (class_out != CLASS_SINGLE || index_out == $past(index_in)))
    else $error("flipped bit index not loaded");
endmodule : l2edc_fault_rec
`default_nettype wire

/* File: hw/l2edc_regs.sv */
// Level-2 EDC status, command and fault-location registers.
// Assumes the register port and the fault report come from logic on mclk_in,
// so no input is synchronised. Read data answers one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - single-bit fault loads flipped bit index
// - class codes 01 double, 11 parity-only
// - status bit 6 flags DMA read fault
// - status bit 5 flags program fetch fault
// - status bit 4 flags data access fault
// - status bit 3 shows suspended mode
// - status bit 2 shows disabled mode
// - status bit 0 shows enabled mode
// - command bit 6 clears DMA flag, location
// - command bit 5 clears program flag, location
// - command bit 4 clears data flag, location
// - command bit 3 enters suspended mode
// - command bit 2 enters disabled mode
// - command bit 0 enters enabled mode
// - several clear bits act together
// - conflicting mode bits act as disable
// - location bits 31..5 hold aligned address
// - way field holds failing cache way
// - location bit 0 marks RAM fault
// - RAM fault forces way field zero
// - suspended mode neither checks nor records
// - record held until software clears it or a double fault replaces a single or parity one
module l2edc_regs (
  input  wire logic                  mclk_in,             // 20 MHz subsystem clock
  input  wire logic                  srst_in,             // Synchronous reset, high
  // Register port
  input  wire logic [31:0]           reg_addr_in,         // Byte address
  input  wire logic                  reg_wr_in,           // Write strobe
  input  wire logic [31:0]           reg_wdata_in,        // Write data
  input  wire logic                  reg_rd_in,           // Read strobe
  output logic      [31:0]           reg_rdata_out,       // Read data
  output logic                       reg_rvalid_out,      // Read data valid
  // Fault report from the access pipeline
  input  wire logic                  fault_valid_in,      // One-cycle report
  input  wire l2edc_pkg::l2edc_src_t fault_src_in,        // Access kind
  input  wire logic [1:0]            fault_class_in,      // Class code
  input  wire logic [7:0]            flipped_bit_index_in, // Bit in 256-bit word
  input  wire logic [26:0]           fault_addr_in,       // Address bits 31..5
  input  wire logic [1:0]            cache_way_index_in,  // Failing way
  input  wire logic                  fault_in_ram_in,     // RAM, not cache
  // Mode and fault state toward the pipeline
  output logic                       edc_enabled_out,     // Check and generate
  output logic                       edc_paused_out,      // Suspended
  output logic                       edc_turned_off_out,  // Disabled
  output logic      [2:0]            fault_flags_out      // {dma, prog, data}
);
  import l2edc_pkg::*;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  logic        cmd_write;    // Write aimed at the command register
  logic [2:0]  clear_pulse;  // Fault clear pulses {dma, prog, data}
  logic        fault_accept; // Recording allowed this cycle

  // Only the command register takes writes; the others are read only
  assign cmd_write = reg_wr_in && (reg_addr_in == L2EDC_CMD_ADDR);

  // Clear bits are one-shot: a zero leaves the flag alone
  assign clear_pulse = cmd_write ? {reg_wdata_in[BIT_DMA],
                                    reg_wdata_in[BIT_PROG],
                                    reg_wdata_in[BIT_DATA]}
                                 : FLAGS_ZERO;

  // ------------------------------------------------------------------
  // Mode control
  // ------------------------------------------------------------------
  l2edc_mode_ctrl u_mode (
    .mclk_in    (mclk_in),
    .srst_in    (srst_in),
    .cmd_wr_in  (cmd_write),
    .pause_in   (reg_wdata_in[BIT_PAUSE]),
    .off_in     (reg_wdata_in[BIT_OFF]),
    .on_in      (reg_wdata_in[BIT_ON]),
    .paused_out (edc_paused_out),
    .off_out    (edc_turned_off_out),
    .on_out     (edc_enabled_out)
  );

  // Faults only count while checking runs; suspended and disabled both
  // ignore reports, so the pipeline may leave its check logic idle then.
  assign fault_accept = edc_enabled_out;

  // ------------------------------------------------------------------
  // Fault record
  // ------------------------------------------------------------------
  logic [1:0]  rec_class; // Recorded class
  logic [7:0]  rec_index; // Recorded flipped bit
  logic [31:0] rec_loc;   // Location register image

  l2edc_fault_rec u_rec (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .accept_in (fault_accept),
    .fault_in  (fault_valid_in),
    .src_in    (fault_src_in),
    .class_in  (fault_class_in),
    .index_in  (flipped_bit_index_in),
    .addr_in   (fault_addr_in),
    .way_in    (cache_way_index_in),
    .ram_in    (fault_in_ram_in),
    .clear_in  (clear_pulse),
    .flags_out (fault_flags_out),
    .class_out (rec_class),
    .index_out (rec_index),
    .loc_out   (rec_loc)
  );

  // ------------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------------
  logic [31:0] status_word; // Assembled status image

  // Start from zero so every reserved bit reads as zero
  always_comb begin
    status_word = L2EDC_ZERO_WORD;
    status_word[STAT_INDEX_LSB +: INDEX_W] = rec_index;
    status_word[STAT_CLASS_LSB +: CLASS_W] = rec_class;
    status_word[BIT_DMA]   = fault_flags_out[FLAG_DMA];
    status_word[BIT_PROG]  = fault_flags_out[FLAG_PROG];
    status_word[BIT_DATA]  = fault_flags_out[FLAG_DATA];
    status_word[BIT_PAUSE] = edc_paused_out;
    status_word[BIT_OFF]   = edc_turned_off_out;
    status_word[BIT_ON]    = edc_enabled_out;
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  // Registered read: data shows the state before any same-cycle write,
  // which keeps the answer free of a combinational path from the port.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      reg_rdata_out <= L2EDC_ZERO_WORD;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        L2EDC_STATUS_ADDR: reg_rdata_out <= status_word;
        L2EDC_LOC_ADDR:    reg_rdata_out <= rec_loc;
        L2EDC_CMD_ADDR:    reg_rdata_out <= L2EDC_ZERO_WORD;  // Write only
        default:           reg_rdata_out <= L2EDC_ZERO_WORD;  // Unmapped
      endcase
    end
  end

  // Every read strobe is answered, mapped or not, so software never hangs
  always_ff @(posedge mclk_in) begin
    if (srst_in) reg_rvalid_out <= 1'b0;
    else reg_rvalid_out <= reg_rd_in;
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Status read returns the mode held in the cycle of the strobe
  status_mode_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (reg_rd_in && reg_addr_in == L2EDC_STATUS_ADDR) |=>
      (reg_rdata_out[BIT_OFF] == $past(edc_turned_off_out) &&
       reg_rdata_out[BIT_ON] == $past(edc_enabled_out) &&
       reg_rdata_out[BIT_PAUSE] == $past(edc_paused_out)))
    else $error("status mode bits differ from mode");

  // Reserved status bits stay zero on every status read
  status_rsvd_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (reg_rd_in && reg_addr_in == L2EDC_STATUS_ADDR) |=>
      (reg_rdata_out[31:24] == 8'h00 && reg_rdata_out[15:10] == 6'h00 &&
       !reg_rdata_out[7] && !reg_rdata_out[1]))
    else $error("reserved status bit set");

  // Suspended or disabled: a fault report raises no flag
  paused_ignore_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (fault_valid_in && !edc_enabled_out) |=>
      ((fault_flags_out & ~$past(fault_flags_out)) == FLAGS_ZERO))
    else $error("fault recorded while not enabled");

  // A write of all zeros to the command register changes nothing
  zero_cmd_write_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (cmd_write && reg_wdata_in == L2EDC_ZERO_WORD && !fault_valid_in) |=>
      ($stable(edc_enabled_out) && $stable(edc_paused_out) && $stable(fault_flags_out)))
    else $error("zero command write had an effect");

  // Single enable write reaches the enabled mode one cycle later
  enable_cmd_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (cmd_write && reg_wdata_in[BIT_ON] && !reg_wdata_in[BIT_OFF] && !reg_wdata_in[BIT_PAUSE])
      |=> edc_enabled_out)
    else $error("enable command not taken");

  // Single suspend write reaches the suspended mode one cycle later
  pause_cmd_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (cmd_write && reg_wdata_in[BIT_PAUSE] && !reg_wdata_in[BIT_OFF] && !reg_wdata_in[BIT_ON])
      |=> (edc_paused_out && !edc_enabled_out))
    else $error("suspend command not taken");

  // An accepted DMA fault on an idle record shows the DMA flag next cycle
  fault_flag_set_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (fault_valid_in && edc_enabled_out && fault_flags_out == FLAGS_ZERO &&
     fault_src_in == SRC_DMA) |=> fault_flags_out[FLAG_DMA])
    else $error("DMA fault flag not set");

  // Writes to the read-only location register leave the location word untouched
  ro_write_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (reg_wr_in && reg_addr_in == L2EDC_LOC_ADDR && !fault_valid_in) |=> $stable(rec_loc))
    else $error("location register took a write");

  // Unmapped reads answer zero with valid one cycle later
  unmapped_read_a : assert property (@(posedge mclk_in) disable iff (srst_in)
    (reg_rd_in && reg_addr_in != L2EDC_STATUS_ADDR && reg_addr_in != L2EDC_LOC_ADDR) |=>
      (reg_rvalid_out && reg_rdata_out == L2EDC_ZERO_WORD))
    else $error("non-readable address returned data");
endmodule : l2edc_regs
`default_nettype wire

/* File: verif/l2edc_pipe_model.sv */
// Access pipeline stand-in: emits one fault report per bench request.
// Assumes fire_in is a one-cycle pulse set just after mclk_in rises.
`timescale 1ns/1ps
`default_nettype none
module l2edc_pipe_model (
  input  wire logic        mclk_in,   // Subsystem clock
  input  wire logic        fire_in,   // Request one report
  input  wire logic [41:0] rec_in,    // {src, class, index, addr, way, ram}
  output logic             valid_out, // One-cycle report strobe
  output logic      [41:0] rec_out    // Report fields
);
  // ------------------------------------------------------------------
  // Report launch
  // ------------------------------------------------------------------
  // Fields flip outside a report, so stale values can never pass as valid
  always_ff @(posedge mclk_in) begin
    valid_out <= fire_in;
    rec_out   <= fire_in ? rec_in : ~rec_out;
  end
endmodule : l2edc_pipe_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the EDC status and command registers.
// Assumes one clock; registers reached by the one-cycle read/write strobes.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import l2edc_pkg::*;
  logic        mclk_in = 0, srst_in = 1, wr = 0, rd = 0, fire = 0, fv, rv, en_o, pa_o, of_o;
  logic [31:0] addr = 0, wdata = 0, rdata;
  logic [41:0] rec = 0, rec_o;     // Report request and launched report
  logic [2:0]  flags;              // Sticky flags {dma, prog, data}
  int          fails = 0, cmp_count = 0, cyc = 0;
  always #25 mclk_in = ~mclk_in;   // 20 MHz
  l2edc_pipe_model l2edc_pipe_model_i (.mclk_in(mclk_in), .fire_in(fire), .rec_in(rec),
    .valid_out(fv), .rec_out(rec_o));
  l2edc_regs l2edc_regs_i (.mclk_in(mclk_in), .srst_in(srst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_rvalid_out(rv), .fault_valid_in(fv), .fault_src_in(l2edc_src_t'(rec_o[41:40])),
    .fault_class_in(rec_o[39:38]), .flipped_bit_index_in(rec_o[37:30]),
    .fault_addr_in(rec_o[29:3]), .cache_way_index_in(rec_o[2:1]), .fault_in_ram_in(rec_o[0]),
    .edc_enabled_out(en_o), .edc_paused_out(pa_o), .edc_turned_off_out(of_o),
    .fault_flags_out(flags));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Write strobe held for exactly one taking edge
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_in) #1;
    addr = a;
    wdata = d;
    wr = 1;
    @(posedge mclk_in) #1;
    wr = 0;
  endtask : wr_reg
  // Read answers one cycle after the strobe, checked in that cycle
  task automatic rd_reg(input logic [31:0] a, input logic [31:0] exp);
    @(posedge mclk_in) #1;
    addr = a;
    rd = 1;
    @(posedge mclk_in) #1;
    rd = 0;
    chk({31'h0, rv}, 32'h0000_0001);
    chk(rdata, exp);
  endtask : rd_reg
  task automatic flt(input logic [1:0] s, c, input logic [7:0] i, input logic [26:0] a,
    input logic [1:0] w, input logic r);
    @(posedge mclk_in) #1;
    rec = {s, c, i, a, w, r};
    fire = 1;
    @(posedge mclk_in) #1;
    fire = 0;
  endtask : flt
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0004);
    rd_reg(L2EDC_CMD_ADDR, 32'h0000_0000);
    rd_reg(32'h0184_6000, 32'h0000_0000);
    rd_reg(L2EDC_LOC_ADDR, 32'h0000_0000);
  endtask : t_reset
  // Every mode command, then conflicting sets that must fall back to off
  task automatic t_modes;
    logic [31:0] c[7] = '{32'h1, 32'h8, 32'h4, 32'hD, 32'hB, 32'h9, 32'h1};
    logic [31:0] e[7] = '{32'h1, 32'h8, 32'h4, 32'h4, 32'h4, 32'h4, 32'h1};
    for (int k = 0; k < 7; k++) begin
      wr_reg(L2EDC_CMD_ADDR, c[k]);
      rd_reg(L2EDC_STATUS_ADDR, e[k]);
    end
    wr_reg(L2EDC_CMD_ADDR, 32'h0000_0000);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0001);
    chk({29'h0, en_o, pa_o, of_o}, 32'h0000_0004);
  endtask : t_modes
  // Capture, hold, double override, partial and multiple clears
  task automatic t_fault;
    flt(SRC_PROG, 2'h0, 8'h07, 27'h123_4567, 2'h2, 1'b0);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0007_0021);
    rd_reg(L2EDC_LOC_ADDR, {27'h123_4567, 5'h10});
    flt(SRC_DATA, 2'h0, 8'h09, 27'h000_0001, 2'h1, 1'b0);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0007_0021);
    flt(SRC_DMA, 2'h1, 8'h05, 27'h7AB_CDEF, 2'h3, 1'b1);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0141);
    rd_reg(L2EDC_LOC_ADDR, {27'h7AB_CDEF, 5'h01});
    wr_reg(L2EDC_STATUS_ADDR, 32'hFFFF_FFFF);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0141);
    wr_reg(L2EDC_CMD_ADDR, 32'h0000_0020);
    rd_reg(L2EDC_LOC_ADDR, 32'h0000_0000);
    wr_reg(L2EDC_CMD_ADDR, 32'h0000_0050);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0101);
    flt(SRC_DATA, 2'h3, 8'h00, 27'h000_0002, 2'h0, 1'b1);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0311);
    wr_reg(L2EDC_CMD_ADDR, 32'h0000_0010);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0301);
    // Reserved class lands as double on an idle record; a parity report then is dropped
    flt(SRC_DMA, 2'h2, 8'h11, 27'h000_0005, 2'h1, 1'b0);
    flt(SRC_DATA, 2'h3, 8'h00, 27'h000_0006, 2'h0, 1'b0);
    chk({29'h0, flags}, 32'h0000_0004);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0141);
    rd_reg(L2EDC_LOC_ADDR, {27'h000_0005, 5'h08});
    wr_reg(L2EDC_CMD_ADDR, 32'h0000_0040);
    rd_reg(L2EDC_LOC_ADDR, 32'h0000_0000);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0101);
  endtask : t_fault
  // Reports while suspended are dropped
  task automatic t_pause;
    wr_reg(L2EDC_CMD_ADDR, 32'h0000_0008);
    flt(SRC_DMA, 2'h1, 8'h00, 27'h000_0003, 2'h0, 1'b1);
    rd_reg(L2EDC_STATUS_ADDR, 32'h0000_0108);
    chk({29'h0, en_o, pa_o, of_o}, 32'h0000_0002);
    chk({29'h0, flags}, 32'h0000_0000);
  endtask : t_pause
  // ------------------------------------------------------------------
  // Closing report and run control
  // ------------------------------------------------------------------
  task automatic results;
    $display("mismatches=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Run needs about 130 cycles; the ceiling cuts a hang short
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    #1 srst_in = 0;
    t_reset();
    t_modes();
    t_fault();
    t_pause();
    // Mid-run reset must bring back the idle record and disabled mode
    @(posedge mclk_in) #1 srst_in = 1;
    repeat (2) @(posedge mclk_in);
    #1 srst_in = 0;
    t_reset();
    results();
  end
endmodule : tb_top
`default_nettype wire
